/* core/tmctl_regs.vh */
// register map, field positions and timing counts of the timer 2 mode control block
// assumes a 20 MHz system clock standing in for the oscillator
`ifndef TMCTL_REGS_VH
`define TMCTL_REGS_VH
// byte addresses on the axi4-lite bus
`define TMCTL_ADDR_CTRL 8'h00
`define TMCTL_ADDR_CNTL 8'h04
`define TMCTL_ADDR_CNTH 8'h08
`define TMCTL_ADDR_RLDL 8'h0C
`define TMCTL_ADDR_RLDH 8'h10
`define TMCTL_ADDR_STAT 8'h14
`define TMCTL_ADDR_MASK 8'h18
// control register fields
`define TMCTL_CTL_CPRL 0
`define TMCTL_CTL_CSEL 1
`define TMCTL_CTL_RUN 2
`define TMCTL_CTL_TEN 3
`define TMCTL_CTL_TX_CLOCK_SELECT 4
`define TMCTL_CTL_RCLK 5
`define TMCTL_CTL_EXF 6
`define TMCTL_CTL_TF 7
// status / mask fields
`define TMCTL_ST_OVF 0
`define TMCTL_ST_TRG 1
`define TMCTL_ST_BAUD 2
// reset values
`define TMCTL_CTRL_RST 8'h00
`define TMCTL_MASK_RST 3'h0
// prescale: oscillator periods per machine cycle and per state time
`define TMCTL_MC_DIV 12
`define TMCTL_ST_DIV 2
`define TMCTL_PRE_W 4
// axi responses
`define TMCTL_RESP_OKAY 2'h0
`define TMCTL_RESP_SLVERR 2'h2
`endif

/* core/tmctl_timer2.v */
// timer 2 counting and mode control with an axi4-lite register slave
// assumes asynchronous external pins, resynchronised here, and a single 20 MHz clock; clk is the oscillator
`include "tmctl_regs.vh"
`default_nettype none
module tmctl_timer2 (
    input wire clk,
    input wire resetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire event_count_pin,
    input wire trigger_pin,
    output reg rx_baud_tick,
    output reg tx_baud_tick,
    output reg irq
);
    // architectural registers first, then the bus holding state
    reg [7:0] timer_control_reg_ff;
    reg [7:0] count_low_ff;
    reg [7:0] count_high_ff;
    reg [7:0] reload_value_low_ff;
    reg [7:0] reload_value_high_ff;
    reg [2:0] stat_ff;
    reg [2:0] mask_ff;
    reg [`TMCTL_PRE_W-1:0] pre_ff;
    reg [1:0] cnt_sync_ff;
    reg [1:0] trg_sync_ff;
    reg cnt_last_ff;
    reg trg_last_ff;
    // write channel halves are held here until both have arrived
    reg aw_ok_ff;
    reg w_ok_ff;
    reg [7:0] aw_addr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;

    // address decode shared by read and write paths
    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a == `TMCTL_ADDR_CTRL) || (a == `TMCTL_ADDR_CNTL) ||
                       (a == `TMCTL_ADDR_CNTH) || (a == `TMCTL_ADDR_RLDL) ||
                       (a == `TMCTL_ADDR_RLDH) || (a == `TMCTL_ADDR_STAT) ||
                       (a == `TMCTL_ADDR_MASK);
        end
    endfunction

    // control field taps; a serial clock select overrides the capture bit
    wire cpr = timer_control_reg_ff[`TMCTL_CTL_CPRL];
    wire count_source_select = timer_control_reg_ff[`TMCTL_CTL_CSEL];
    wire run_control = timer_control_reg_ff[`TMCTL_CTL_RUN];
    wire trigger_enable = timer_control_reg_ff[`TMCTL_CTL_TEN];
    wire tx_clock_select = timer_control_reg_ff[`TMCTL_CTL_TX_CLOCK_SELECT];
    wire rx_clock_select = timer_control_reg_ff[`TMCTL_CTL_RCLK];
    wire baud_mode = tx_clock_select | rx_clock_select;
    wire capture_not_reload = cpr & ~baud_mode;

    // falling edges judged from the second sync stage only
    wire cnt_fall = cnt_last_ff & ~cnt_sync_ff[1];
    wire trg_fall = trg_last_ff & ~trg_sync_ff[1];

    // prescaler: 12 clocks per machine cycle, 2 per state time in baud mode
    // terminal counts are cut to the prescaler width on purpose; both fit in it
    localparam [31:0] PRE_MC_FULL = `TMCTL_MC_DIV - 1;
    localparam [31:0] PRE_ST_FULL = `TMCTL_ST_DIV - 1;
    wire [`TMCTL_PRE_W-1:0] pre_top = baud_mode ? PRE_ST_FULL[`TMCTL_PRE_W-1:0] :
                                                  PRE_MC_FULL[`TMCTL_PRE_W-1:0];
    // >= rather than == so a switch to the shorter prescale never runs past the top
    wire pre_tick = (pre_ff >= pre_top);
    // external edges stand in for the prescaler, which then runs unused
    wire step_src = count_source_select ? cnt_fall : pre_tick;
    wire step = run_control & step_src;
    wire [15:0] count = {count_high_ff, count_low_ff};
    wire [15:0] reload = {reload_value_high_ff, reload_value_low_ff};
    wire rollover = step & (count == 16'hFFFF);
    // trigger acts only while enabled and not feeding the serial port
    wire trg_act = trg_fall & trigger_enable & ~baud_mode;
    wire trg_seen = trg_fall & trigger_enable; // flag still sets in baud mode

    // axi write handshake
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_ok_ff | aw_take;
    wire w_have = w_ok_ff | w_take;
    wire wr_go = aw_have & w_have & ~s_axi_bvalid;
    wire [7:0] wr_addr = aw_ok_ff ? aw_addr_ff : s_axi_awaddr;
    wire [31:0] wr_data = w_ok_ff ? wdata_ff : s_axi_wdata;
    wire [3:0] wr_strb = w_ok_ff ? wstrb_ff : s_axi_wstrb;
    wire wr_b0 = wr_go & wr_strb[0];
    wire sw_ctrl = wr_b0 & (wr_addr == `TMCTL_ADDR_CTRL);
    wire sw_cntl = wr_b0 & (wr_addr == `TMCTL_ADDR_CNTL);
    wire sw_cnth = wr_b0 & (wr_addr == `TMCTL_ADDR_CNTH);
    wire sw_stat = wr_b0 & (wr_addr == `TMCTL_ADDR_STAT);

    // event set and write-one-to-clear, set wins
    // baud rollover gets a bit of its own since it must leave the overflow bit alone
    wire [2:0] ev = {rollover & baud_mode, trg_seen, rollover & ~baud_mode};
    wire [2:0] w1c = sw_stat ? wr_data[2:0] : 3'h0;
    wire [2:0] nxt_stat = (stat_ff & ~w1c) | ev;

    // control flags mirror overflow and trigger; they too keep set over clear
    reg [7:0] nxt_ctrl;
    always @* begin
        nxt_ctrl = timer_control_reg_ff;
        if (sw_ctrl) begin
            nxt_ctrl = wr_data[7:0];
        end
        if (rollover & ~baud_mode) begin
            nxt_ctrl[`TMCTL_CTL_TF] = 1'b1;
        end
        if (trg_seen) begin
            nxt_ctrl[`TMCTL_CTL_EXF] = 1'b1;
        end
    end

    // counter: reload, capture, increment; software write has lowest priority
    // in capture mode a rollover wraps to zero and only raises the overflow flag
    reg [15:0] nxt_count;
    always @* begin
        nxt_count = count;
        if (sw_cntl) begin
            nxt_count[7:0] = wr_data[7:0];
        end
        if (sw_cnth) begin
            nxt_count[15:8] = wr_data[7:0];
        end
        if (step) begin
            nxt_count = count + 16'h0001;
        end
        if (rollover & ~capture_not_reload) begin
            nxt_count = reload;
        end
        if (trg_act & ~capture_not_reload) begin
            nxt_count = reload;
        end
    end

    // capture of the running count, or software load of the pair
    reg [15:0] nxt_reload;
    always @* begin
        nxt_reload = reload;
        if (wr_b0 && (wr_addr == `TMCTL_ADDR_RLDL)) begin
            nxt_reload[7:0] = wr_data[7:0];
        end
        if (wr_b0 && (wr_addr == `TMCTL_ADDR_RLDH)) begin
            nxt_reload[15:8] = wr_data[7:0];
        end
        if (trg_act & capture_not_reload) begin
            nxt_reload = count;
        end
    end

    // read mux
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h00000000;
        case (s_axi_araddr)
            `TMCTL_ADDR_CTRL: rd_mux[7:0] = timer_control_reg_ff;
            `TMCTL_ADDR_CNTL: rd_mux[7:0] = count_low_ff;
            `TMCTL_ADDR_CNTH: rd_mux[7:0] = count_high_ff;
            `TMCTL_ADDR_RLDL: rd_mux[7:0] = reload_value_low_ff;
            `TMCTL_ADDR_RLDH: rd_mux[7:0] = reload_value_high_ff;
            `TMCTL_ADDR_STAT: rd_mux[2:0] = stat_ff;
            `TMCTL_ADDR_MASK: rd_mux[2:0] = mask_ff;
            default: rd_mux = 32'h00000000;
        endcase
    end

    // pin synchronisers and edge history, reset high to match the idle pins
    // so that leaving reset never fakes a falling edge
    always @(posedge clk) begin
        if (!resetn) begin
            cnt_sync_ff <= 2'h3;
            trg_sync_ff <= 2'h3;
            cnt_last_ff <= 1'b1;
            trg_last_ff <= 1'b1;
        end else begin
            cnt_sync_ff <= {cnt_sync_ff[0], event_count_pin};
            trg_sync_ff <= {trg_sync_ff[0], trigger_pin};
            cnt_last_ff <= cnt_sync_ff[1];
            trg_last_ff <= trg_sync_ff[1];
        end
    end

    // timer core; prescaler is cleared while stopped
    always @(posedge clk) begin
        if (!resetn) begin
            timer_control_reg_ff <= `TMCTL_CTRL_RST;
            count_low_ff <= 8'h00;
            count_high_ff <= 8'h00;
            reload_value_low_ff <= 8'h00;
            reload_value_high_ff <= 8'h00;
            stat_ff <= 3'h0;
            mask_ff <= `TMCTL_MASK_RST;
            pre_ff <= {`TMCTL_PRE_W{1'b0}};
            rx_baud_tick <= 1'b0;
            tx_baud_tick <= 1'b0;
            irq <= 1'b0;
        end else begin
            timer_control_reg_ff <= nxt_ctrl;
            {count_high_ff, count_low_ff} <= nxt_count;
            {reload_value_high_ff, reload_value_low_ff} <= nxt_reload;
            stat_ff <= nxt_stat;
            if (wr_b0 && (wr_addr == `TMCTL_ADDR_MASK)) begin
                mask_ff <= wr_data[2:0];
            end
            if (!run_control || pre_tick) begin
                pre_ff <= {`TMCTL_PRE_W{1'b0}};
            end else begin
                pre_ff <= pre_ff + {{(`TMCTL_PRE_W-1){1'b0}}, 1'b1};
            end
            rx_baud_tick <= rollover & rx_clock_select;
            tx_baud_tick <= rollover & tx_clock_select;
            // irq follows the next status so a clear drops it without an extra cycle
            irq <= |(nxt_stat & mask_ff);
        end
    end

    // axi4-lite slave: one write and one read at a time
    always @(posedge clk) begin
        if (!resetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMCTL_RESP_OKAY;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `TMCTL_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_ok_ff <= 1'b0;
                w_ok_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_hit(wr_addr) ? `TMCTL_RESP_OKAY : `TMCTL_RESP_SLVERR;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end else begin
                if (aw_take) begin
                    aw_ok_ff <= 1'b1;
                    s_axi_awready <= 1'b0;
                end
                if (w_take) begin
                    w_ok_ff <= 1'b1;
                    s_axi_wready <= 1'b0;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                    s_axi_awready <= 1'b1;
                    s_axi_wready <= 1'b1;
                end
            end
            // read path runs beside the write path; arready stays low while data waits
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= addr_hit(s_axi_araddr) ? `TMCTL_RESP_OKAY : `TMCTL_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // tmctl_timer2
`default_nettype wire

/* sim/tmctl_pin_model.sv */
// far-side model of the external count and trigger pins
// assumes the bench calls pulse from its main sequence, one caller at a time
`default_nettype none
module tmctl_pin_model (
    input wire logic clk,
    output logic event_count_pin,
    output logic trigger_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    // both pins idle high, so only a deliberate drop makes a falling edge
    initial begin
        event_count_pin = 1'b1;
        trigger_pin = 1'b1;
    end
    // each level held three clocks: resampler needs two, the extra one gives margin
    task automatic pulse(input bit trg, input int n);
        repeat (n) begin
            @(posedge clk);
            {trigger_pin, event_count_pin} <= trg ? 2'h1 : 2'h2;
            repeat (3) @(posedge clk);
            {trigger_pin, event_count_pin} <= 2'h3;
            repeat (3) @(posedge clk);
        end
    endtask
endmodule // tmctl_pin_model
`default_nettype wire

/* sim/tmctl_timer2_properties.sv */
// port checker for the timer 2 block: bus handshakes and baud tick pulses
// assumes the single clk domain with synchronous active-low resetn
`default_nettype none
module tmctl_timer2_properties (
    input wire logic clk,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_baud_tick,
    input wire logic tx_baud_tick
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // transfer steps as the slave sees them
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_take |=> s_axi_bvalid && !s_axi_awready)
        else $error("write not answered one cycle after taking");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response not held");
    a_bvalid_drops: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response outstays its handshake");
    a_read_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered one cycle after taking");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_rvalid_drops: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data outstays its handshake");
    a_tx_tick_single: assert property (tx_baud_tick |=> !tx_baud_tick)
        else $error("tx tick longer than one cycle");
    a_rx_tick_single: assert property (rx_baud_tick |=> !rx_baud_tick)
        else $error("rx tick longer than one cycle");
endmodule // tmctl_timer2_properties
bind tmctl_timer2 tmctl_timer2_properties u_props (.*);
`default_nettype wire

/* sim/timer2_mode_control_tb_top.sv */
// self-checking bench for timer 2 mode control, random counts from a fixed seed
// assumes the register map header and the pin model; 50 ns clock
`include "tmctl_regs.vh"
`default_nettype none
module timer2_mode_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] aw = 8'h00, ar = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic awr, wrdy, bv, arr, rv, ecp, tgp, rxt, txt, irq;
    logic [1:0] bresp, rresp;
    int n_errors = 0, cmp_count = 0, n_tx = 0, n_rx = 0;
    always #25 clk = ~clk;
    // tick tallies, read as differences across a window
    always @(posedge clk) begin
        n_tx <= n_tx + int'(txt === 1'b1);
        n_rx <= n_rx + int'(rxt === 1'b1);
    end
    tmctl_pin_model pm (.clk(clk), .event_count_pin(ecp), .trigger_pin(tgp));
    tmctl_timer2 uut (.clk(clk), .resetn(resetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .event_count_pin(ecp),
        .trigger_pin(tgp), .rx_baud_tick(rxt), .tx_baud_tick(txt), .irq(irq));
    // range compare; an unknown never lands inside the range
    task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        cmp_count++;
        if (!(got === lo || (got > lo && got <= hi) === 1'b1)) begin
            n_errors++;
            $display("[FAIL] %0t got %0h want %0h..%0h", $time, got, lo, hi);
        end
    endtask
    // bus write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e = 2'h0);
        @(posedge clk);
        aw <= a;
        wd <= {24'h0, d};
        {awv, wv, br} <= 3'h7;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv && br) begin
                br <= 1'b0;
                chk({30'h0, bresp}, e, e);
            end
        end while (awv || wv || br);
    endtask
    // bus read with data range and response compare
    task automatic rc(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi,
            input logic [1:0] e = 2'h0);
        @(posedge clk);
        ar <= a;
        {arv, rr} <= 2'h3;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv && rr) begin
                rr <= 1'b0;
                chk(rdat, lo, hi);
                chk({30'h0, rresp}, e, e);
            end
        end while (arv || rr);
    endtask
    task automatic wrap_up();
        if (n_errors == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog, far beyond the thousand or so cycles the sequence needs
    initial begin
        #(50 * 20000);
        n_errors++;
        wrap_up();
    end
    // main sequence: reset values, bus errors, then each counting mode in turn
    initial begin
        logic [7:0] n, rl;
        int t0, r0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        void'($urandom(17775));
        n = 8'($urandom_range(9, 2));
        rl = 8'($urandom_range(254, 1));
        rc(`TMCTL_ADDR_CTRL, 0, 0);
        rc(`TMCTL_ADDR_MASK, 0, 0);
        rc(8'h1C, 0, 0, `TMCTL_RESP_SLVERR);
        wr(8'h1C, 8'hFF, `TMCTL_RESP_SLVERR);
        wr(`TMCTL_ADDR_CTRL, 8'h04);
        repeat (240) @(posedge clk);
        wr(`TMCTL_ADDR_CTRL, 8'h00);
        rc(`TMCTL_ADDR_CNTL, 19, 21);
        wr(`TMCTL_ADDR_CNTL, 8'h00);
        wr(`TMCTL_ADDR_CTRL, 8'h14);
        repeat (240) @(posedge clk);
        wr(`TMCTL_ADDR_CTRL, 8'h00);
        rc(`TMCTL_ADDR_CNTL, 120, 123);
        // baud mode with capture bit and trigger set: neither acts, the trigger only sets its flag, rollovers reload
        wr(`TMCTL_ADDR_RLDL, 8'hF0);
        wr(`TMCTL_ADDR_RLDH, 8'hFF);
        wr(`TMCTL_ADDR_CNTH, 8'hFF);
        wr(`TMCTL_ADDR_CNTL, 8'hF0); // start one reload period short of rollover
        wr(`TMCTL_ADDR_STAT, 8'h07);
        {t0, r0} = {n_tx, n_rx};
        wr(`TMCTL_ADDR_CTRL, 8'h3D);
        pm.pulse(1'b1, 1);
        repeat (300) @(posedge clk);
        wr(`TMCTL_ADDR_CTRL, 8'h00);
        chk(n_tx - t0, 8, 11);
        chk(n_rx - r0, 8, 11);
        rc(`TMCTL_ADDR_CNTH, 8'hFF, 8'hFF);
        rc(`TMCTL_ADDR_RLDL, 8'hF0, 8'hF0);
        rc(`TMCTL_ADDR_STAT, 6, 6);
        // event counting, stopped counting, capture and ignored trigger
        wr(`TMCTL_ADDR_CNTL, 8'h00);
        wr(`TMCTL_ADDR_CNTH, 8'h00);
        wr(`TMCTL_ADDR_CTRL, 8'h06);
        pm.pulse(1'b0, n);
        rc(`TMCTL_ADDR_CNTL, n, n);
        wr(`TMCTL_ADDR_CTRL, 8'h02);
        pm.pulse(1'b0, 3);
        rc(`TMCTL_ADDR_CNTL, n, n);
        wr(`TMCTL_ADDR_CTRL, 8'h0F);
        pm.pulse(1'b0, 2);
        pm.pulse(1'b1, 1);
        rc(`TMCTL_ADDR_RLDL, n + 2, n + 2);
        rc(`TMCTL_ADDR_RLDH, 0, 0);
        wr(`TMCTL_ADDR_CTRL, 8'h07);
        pm.pulse(1'b0, 1);
        pm.pulse(1'b1, 1);
        rc(`TMCTL_ADDR_RLDL, n + 2, n + 2);
        // reload by trigger, then by overflow with the interrupt masked and cleared
        wr(`TMCTL_ADDR_RLDL, rl);
        wr(`TMCTL_ADDR_CTRL, 8'h0E);
        pm.pulse(1'b1, 1);
        rc(`TMCTL_ADDR_CNTL, rl, rl);
        wr(`TMCTL_ADDR_RLDH, 8'h12);
        wr(`TMCTL_ADDR_CNTL, 8'hFF);
        wr(`TMCTL_ADDR_CNTH, 8'hFF);
        wr(`TMCTL_ADDR_STAT, 8'h07);
        wr(`TMCTL_ADDR_MASK, 8'h01);
        pm.pulse(1'b0, 1);
        rc(`TMCTL_ADDR_CNTH, 8'h12, 8'h12);
        chk({31'h0, irq}, 1, 1);
        wr(`TMCTL_ADDR_MASK, 8'h00);
        chk({31'h0, irq}, 0, 0);
        wr(`TMCTL_ADDR_MASK, 8'h01);
        chk({31'h0, irq}, 1, 1);
        wr(`TMCTL_ADDR_STAT, 8'h01);
        chk({31'h0, irq}, 0, 0);
        wrap_up();
    end
endmodule // timer2_mode_control_tb_top
`default_nettype wire
